// ==== logic/ctm_params.svh ====
// Register offsets, field positions, reset values and timing counts of the compact timer
`ifndef CTM_PARAMS_SVH
`define CTM_PARAMS_SVH
`define CTM_OFF_CTRL0      4'h0
`define CTM_OFF_CTRL1      4'h1
`define CTM_OFF_CNT_LO     4'h2
`define CTM_OFF_CNT_HI     4'h3
`define CTM_OFF_MATCH_LO   4'h4
`define CTM_OFF_MATCH_HI   4'h5
`define CTM_OFF_FLAGS      4'h6
`define CTM_C0_PAUSE       7
`define CTM_C0_ENABLE      3
`define CTM_C1_SWAP        1
`define CTM_C1_CLRSEL      0
`define CTM_C1_POL         2
`define CTM_C1_INIT        3
`define CTM_FLG_MATCH      0
`define CTM_FLG_PERIOD     1
`define CTM_RST_BYTE       8'h00
`define CTM_CNT_MAX        10'h3FF
`define CTM_PERIOD_STEP    11'h080
`define CTM_PERIOD_ZERO    11'h400
`endif

// ==== logic/ctm_pkg.sv ====
// Types shared by the compact timer
package ctm_pkg;
  typedef enum logic [1:0] {
    CTM_MODE_COMPARE = 2'h0,
    CTM_MODE_UNDEF   = 2'h1,
    CTM_MODE_PWM     = 2'h2,
    CTM_MODE_TIMER   = 2'h3
  } ctm_mode_t;
  typedef enum logic [1:0] {
    CTM_BUS_IDLE,
    CTM_BUS_ANSWER
  } ctm_bus_t;
endpackage

// ==== logic/compact_timer.sv ====
// Compact 10-bit timer with compare, timer and PWM modes behind an Avalon-MM slave
// Notes on behaviour
// - Swap bit exchanges period and duty roles
// - Clear-select one clears on compare match
// - Clear-select zero clears on period match
// - PWM mode ignores clear-select
// - Counter readable as two read-only bytes
// - Compare value held in two writable bytes
// - Mode field picks compare, PWM, timer
// - Clear-select zero raises both match flags
// - Clear-select one never raises period flag outside PWM
// - Compare zero overflows without compare flag
// - Of the two matches, only compare match moves the pin
// - Pin action sets, clears, toggles, or holds
// - Enable rising loads pin initial level
// - Timer mode counts but leaves pin alone
// - PWM raises both flags on matches
// - PWM active level and forced levels
// - Polarity bit inverts the pin
// - Swap zero: period steps of 128
// - Duty at or above period holds active
// - Swap one: period is compare value
// - Forced levels keep PWM engine running
// - Enable rise zeroes, fall holds count
// - Period compares counter bits nine to seven
// - Pause freezes and resumes the count
// - Initial-level bit sets initial level or active level
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "ctm_params.svh"
module compact_timer
  import ctm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  input  wire logic        cntTick,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             timerOut,
  output logic             timerOutEn
);

  // Register map by word index
  //   0 control zero
  //     bit 7    pause, freezes the count
  //     bit 3    enable, rise zeroes count and loads pin
  //     bits 6:4 clock select, stored only
  //     bits 2:0 three-bit period value
  //   1 control one
  //     bits 7:6 mode: compare, undefined, PWM, timer
  //     bits 5:4 pin action
  //     bit 3    initial level or active level
  //     bit 2    output invert
  //     bit 1    period and duty swap
  //     bit 0    clear select
  //   2 count low byte, read only
  //   3 count bits 9:8, read only
  //   4 match value low byte
  //   5 match value bits 9:8
  //   6 flags: bit 0 compare, bit 1 period, write one clears
  // Hazard: mode, pin action and swap should change only while disabled

  // Register state
  logic [7:0]  ctrl0_ff, nxt_ctrl0;
  logic [7:0]  ctrl1_ff, nxt_ctrl1;
  logic [9:0]  match_ff, nxt_match;
  logic [9:0]  count_ff, nxt_count;
  logic [1:0]  flags_ff, nxt_flags;
  logic        enPrev_ff, nxt_enPrev;
  logic        pinRaw_ff, nxt_pinRaw;
  logic        timerOut_ff, nxt_timerOut;
  logic        timerOutEn_ff, nxt_timerOutEn;
  logic [31:0] readdata_ff, nxt_readdata;
  logic        wait_ff, nxt_wait;
  ctm_bus_t    bus_ff, nxt_bus;
  logic        tickS1_ff, tickS2_ff;

  // Decoded controls
  ctm_mode_t   mode;
  logic        enable, pause, swap, clrSel, invert, initLvl;
  logic [1:0]  pinAct;
  logic [2:0]  period3;
  logic        matchA, matchP, overflow, clearCnt, enRise, counting;
  logic [10:0] pwmPeriod, pwmDuty, p3Counts;
  logic        pwmActive, accept;
  logic [9:0]  nextCount;
  logic [1:0]  flagSet;
  logic        flagWrite;

  assign mode    = ctm_mode_t'(ctrl1_ff[7:6]);
  assign pinAct  = ctrl1_ff[5:4];
  assign initLvl = ctrl1_ff[`CTM_C1_INIT];
  assign invert  = ctrl1_ff[`CTM_C1_POL];
  assign swap    = ctrl1_ff[`CTM_C1_SWAP];
  assign clrSel  = ctrl1_ff[`CTM_C1_CLRSEL];
  assign enable  = ctrl0_ff[`CTM_C0_ENABLE];
  assign pause   = ctrl0_ff[`CTM_C0_PAUSE];
  assign period3 = ctrl0_ff[2:0];

  // Counts of a 3-bit period value, zero meaning the full range
  function automatic logic [10:0] ctm_p3_counts(input logic [2:0] p);
    ctm_p3_counts = (p == 3'h0) ? `CTM_PERIOD_ZERO : {1'b0, p, 7'h00};
  endfunction

  // Register decode for the write path and flag clear; reads decode with their own case
  function automatic logic ctm_hit(input logic [3:0] a, input logic [3:0] off);
    ctm_hit = (a == off);
  endfunction

  // Two-flop synchroniser for the external count tick
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tickS1_ff <= 1'b0;
      tickS2_ff <= 1'b0;
    end else if (clkEn) begin
      tickS1_ff <= cntTick;
      tickS2_ff <= tickS1_ff;
    end
  end

  // Comparators and clear selection
  always_comb begin
    p3Counts  = ctm_p3_counts(period3);
    counting  = enable && !pause && tickS2_ff;
    enRise    = enable && !enPrev_ff;
    nextCount = count_ff + 10'h001;
    // Matches look one count ahead, so a clear gives exact periods
    matchP    = counting && (period3 != 3'h0) && (nextCount[9:7] == period3) && (nextCount[6:0] == 7'h00);
    matchA    = counting && (match_ff != 10'h000) && (nextCount == match_ff);
    overflow  = counting && (count_ff == `CTM_CNT_MAX);
    if (mode == CTM_MODE_PWM) begin
      // Swap picks which comparator ends the period
      clearCnt = swap ? matchA : (matchP || (period3 == 3'h0 && overflow));
      pwmPeriod = swap ? {1'b0, match_ff} : p3Counts;
      pwmDuty   = swap ? p3Counts : {1'b0, match_ff};
    end else begin
      clearCnt = clrSel ? (matchA || overflow) : (matchP || (period3 == 3'h0 && overflow));
      pwmPeriod = p3Counts;
      pwmDuty   = {1'b0, match_ff};
    end
    // Active from clear until duty reached, always when duty covers period
    pwmActive = (pwmDuty >= pwmPeriod) || ({1'b0, count_ff} < pwmDuty);
  end

  // Counter and flag set terms
  always_comb begin
    nxt_count  = count_ff;
    nxt_enPrev = enable;
    flagSet    = 2'h0;
    if (enRise) begin
      nxt_count = 10'h000;
    end else if (counting) begin
      nxt_count = clearCnt ? 10'h000 : nextCount;
    end
    // Compare flag from comparator A in every mode
    if (matchA) begin
      flagSet[`CTM_FLG_MATCH] = 1'b1;
    end
    // Period flag suppressed when compare match clears outside PWM
    if (matchP && (mode == CTM_MODE_PWM || !clrSel)) begin
      flagSet[`CTM_FLG_PERIOD] = 1'b1;
    end
    nxt_flags = flags_ff | flagSet;
  end

  // Output pin level and drive enable
  always_comb begin
    nxt_pinRaw     = pinRaw_ff;
    nxt_timerOut   = timerOut_ff;
    nxt_timerOutEn = (mode == CTM_MODE_COMPARE) || (mode == CTM_MODE_PWM);
    if (enRise) begin
      nxt_pinRaw = initLvl;
    end
    if (mode == CTM_MODE_COMPARE && matchA && !enRise) begin
      case (pinAct)
        2'h1:    nxt_pinRaw = 1'b0;
        2'h2:    nxt_pinRaw = 1'b1;
        2'h3:    nxt_pinRaw = !pinRaw_ff;
        default: nxt_pinRaw = pinRaw_ff;
      endcase
    end
    case (mode)
      CTM_MODE_COMPARE: nxt_timerOut = nxt_pinRaw ^ invert;
      CTM_MODE_PWM: begin
        case (pinAct)
          2'h0:    nxt_timerOut = !initLvl ^ invert;
          2'h1:    nxt_timerOut = initLvl ^ invert;
          2'h2:    nxt_timerOut = (pwmActive ? initLvl : !initLvl) ^ invert;
          default: nxt_timerOut = timerOut_ff;
        endcase
      end
      default: nxt_timerOut = 1'b0;
    endcase
  end

  // Avalon-MM slave: one wait cycle, then answer
  always_comb begin
    nxt_ctrl0    = ctrl0_ff;
    nxt_ctrl1    = ctrl1_ff;
    nxt_match    = match_ff;
    nxt_readdata = readdata_ff;
    nxt_bus      = bus_ff;
    nxt_wait     = 1'b1;
    accept       = 1'b0;
    case (bus_ff)
      CTM_BUS_IDLE: begin
        if (read || write) begin
          nxt_bus  = CTM_BUS_ANSWER;
          nxt_wait = 1'b0;
        end
      end
      CTM_BUS_ANSWER: begin
        accept  = 1'b1;
        nxt_bus = CTM_BUS_IDLE;
      end
      default: nxt_bus = CTM_BUS_IDLE;
    endcase
    if (accept && write && byteenable[0]) begin
      if (ctm_hit(address, `CTM_OFF_CTRL0)) nxt_ctrl0 = writedata[7:0];
      if (ctm_hit(address, `CTM_OFF_CTRL1)) nxt_ctrl1 = writedata[7:0];
      if (ctm_hit(address, `CTM_OFF_MATCH_LO)) nxt_match[7:0] = writedata[7:0];
      if (ctm_hit(address, `CTM_OFF_MATCH_HI)) nxt_match[9:8] = writedata[1:0];
    end
    if (!accept && bus_ff == CTM_BUS_IDLE && (read || write)) begin
      nxt_readdata = 32'h0000_0000;
      if (read) begin
        // Unmapped words and unused upper bits read as zero
        case (address)
          `CTM_OFF_CTRL0:    nxt_readdata[7:0] = ctrl0_ff;
          `CTM_OFF_CTRL1:    nxt_readdata[7:0] = ctrl1_ff;
          `CTM_OFF_CNT_LO:   nxt_readdata[7:0] = count_ff[7:0];
          `CTM_OFF_CNT_HI:   nxt_readdata[1:0] = count_ff[9:8];
          `CTM_OFF_MATCH_LO: nxt_readdata[7:0] = match_ff[7:0];
          `CTM_OFF_MATCH_HI: nxt_readdata[1:0] = match_ff[9:8];
          `CTM_OFF_FLAGS:    nxt_readdata[1:0] = flags_ff;
          default:           nxt_readdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // Flag clear by writing one; a hardware set in the same cycle wins
  logic [1:0] flagsOut;
  assign flagWrite = accept && write && byteenable[0] && ctm_hit(address, `CTM_OFF_FLAGS);
  for (genvar f = 0; f < 2; f++) begin : gFlag
    // Clear only a bit that is not being set now
    assign flagsOut[f] = (flagWrite && writedata[f] && !flagSet[f]) ? 1'b0 : nxt_flags[f];
  end

  // Control and match registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl0_ff <= `CTM_RST_BYTE;
      ctrl1_ff <= `CTM_RST_BYTE;
      match_ff <= 10'h000;
    end else if (clkEn) begin
      ctrl0_ff <= nxt_ctrl0;
      ctrl1_ff <= nxt_ctrl1;
      match_ff <= nxt_match;
    end
  end

  // Counter, flags and enable history
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_ff  <= 10'h000;
      flags_ff  <= 2'h0;
      enPrev_ff <= 1'b0;
    end else if (clkEn) begin
      count_ff  <= nxt_count;
      flags_ff  <= flagsOut;
      enPrev_ff <= nxt_enPrev;
    end
  end

  // Pin registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pinRaw_ff     <= 1'b0;
      timerOut_ff   <= 1'b0;
      timerOutEn_ff <= 1'b0;
    end else if (clkEn) begin
      pinRaw_ff     <= nxt_pinRaw;
      timerOut_ff   <= nxt_timerOut;
      timerOutEn_ff <= nxt_timerOutEn;
    end
  end

  // Bus registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      readdata_ff <= 32'h0000_0000;
      wait_ff     <= 1'b1;
      bus_ff      <= CTM_BUS_IDLE;
    end else if (clkEn) begin
      readdata_ff <= nxt_readdata;
      wait_ff     <= nxt_wait;
      bus_ff      <= nxt_bus;
    end
  end

  assign readdata    = readdata_ff;
  assign waitrequest = wait_ff;
  assign timerOut    = timerOut_ff;
  assign timerOutEn  = timerOutEn_ff;

endmodule // compact_timer

// ==== testbench/ctm_asserts.sv ====
// Port assertions for the compact timer
`timescale 1ns/100ps
module ctm_asserts
  import ctm_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        timerOut,
  input wire logic        timerOutEn
);
  logic [7:0] c0_ff, c1_ff, nxt_c0, nxt_c1;
  logic       acc;
  // Shadow of accepted control writes
  always_comb begin
    acc    = write && !waitrequest && byteenable[0];
    nxt_c0 = (acc && address == 4'h0) ? writedata[7:0] : c0_ff;
    nxt_c1 = (acc && address == 4'h1) ? writedata[7:0] : c1_ff;
  end
  always_ff @(posedge clk) begin
    c0_ff <= reset_n ? nxt_c0 : 8'h00;
    c1_ff <= reset_n ? nxt_c1 : 8'h00;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_ANSWER_NEXT: assert property ($rose(read) |=> !waitrequest)
    else $error("read not answered next cycle");
  AST_ANSWER_PULSE: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  AST_CNT_HIGH_ZERO: assert property (read && !waitrequest && address == 4'h3 |-> readdata[31:2] == 30'h0)
    else $error("count high upper bits set");
  AST_CNT_LOW_BYTE: assert property (read && !waitrequest && address == 4'h2 |-> readdata[31:8] == 24'h0)
    else $error("count low wider than a byte");
  AST_MATCH_HIGH_ZERO: assert property (read && !waitrequest && address == 4'h5 |-> readdata[31:2] == 30'h0)
    else $error("match high upper bits set");
  AST_TIMER_PIN_FREE: assert property ((c1_ff[7:6] == 2'h3) [*4] |-> !timerOutEn)
    else $error("pin driven in timer mode");
  AST_COMPARE_PIN_DRIVEN: assert property ((c1_ff[7:6] == 2'h0) [*4] |-> timerOutEn)
    else $error("pin not driven in compare mode");
  AST_INIT_LEVEL: assert property ($rose(c0_ff[3]) && c1_ff[7:6] == 2'h0 |-> ##2 timerOut == (c1_ff[3] ^ c1_ff[2]))
    else $error("pin not at initial level");
endmodule // ctm_asserts

// ==== testbench/compact_timer_test.sv ====
// Self-checking bench for the compact timer
`timescale 1ns/100ps
module compact_timer_test;
  logic        clk, reset_n, read, write, timerOut, timerOutEn, waitrequest;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, rd, prev;
  int          bad_count, total_checks, cycles, highs;
  logic [3:0]  regs [5] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'hF};
  logic [7:0]  modes [6] = '{8'hA8, 8'hAC, 8'hA9, 8'h88, 8'h98, 8'hAA};
  logic [31:0] expHi [6] = '{32'h100, 32'h300, 32'h100, 32'h0, 32'h400, 32'h400};
  logic [31:0] expFl [6] = '{32'h3, 32'h3, 32'h3, 32'h3, 32'h3, 32'h1};
  compact_timer dut (.clk, .reset_n, .clkEn(1'b1), .cntTick(1'b1), .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .timerOut, .timerOutEn);
  // Clock and cycle limit
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // One Avalon cycle, held until waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    byteenable = 4'hF;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    foreach (regs[i]) begin
      bus(1'b0, regs[i], 32'h0);
      check(rd, 32'h0);
    end
    bus(1'b1, 4'h4, 32'hAB);
    bus(1'b1, 4'h5, 32'hFE);
    byteenable <= 4'hE;
    bus(1'b1, 4'h4, 32'h55);
    byteenable <= 4'hF;
    bus(1'b0, 4'h4, 32'h0);
    check(rd, 32'hAB);
    bus(1'b0, 4'h5, 32'h0);
    check(rd, 32'h2);
    // Compare mode, clear on compare at 512, period 128 below it
    bus(1'b1, 4'h4, 32'h0);
    bus(1'b1, 4'h1, 32'h21);
    bus(1'b1, 4'h0, 32'h09);
    repeat (600) @(posedge clk);
    check(timerOut, 1'b1);
    bus(1'b0, 4'h6, 32'h0);
    check(rd, 32'h1);
    bus(1'b1, 4'h0, 32'h89);
    bus(1'b0, 4'h2, 32'h0);
    prev = rd;
    bus(1'b0, 4'h2, 32'h0);
    check(rd, prev);
    // Timer mode after a fresh enable
    bus(1'b1, 4'h0, 32'h01);
    bus(1'b1, 4'h1, 32'hC0);
    bus(1'b1, 4'h0, 32'h09);
    bus(1'b0, 4'h2, 32'h0);
    check(32'(rd < 32'h8), 32'h1);
    check(timerOutEn, 1'b0);
    // PWM table: duty 32 against period 128 or swapped
    bus(1'b1, 4'h4, 32'h20);
    bus(1'b1, 4'h5, 32'h0);
    foreach (modes[i]) begin
      bus(1'b1, 4'h0, 32'h01);
      bus(1'b1, 4'h6, 32'h3);
      bus(1'b1, 4'h1, {24'h0, modes[i]});
      bus(1'b1, 4'h0, 32'h09);
      repeat (4) @(posedge clk);
      highs = 0;
      repeat (1024) @(posedge clk) highs += int'(timerOut === 1'b1);
      check(32'(highs), expHi[i]);
      bus(1'b0, 4'h6, 32'h0);
      check(rd & 32'h3, expFl[i]);
    end
    final_report();
  end
endmodule // compact_timer_test
bind compact_timer ctm_asserts chk (.clk, .reset_n, .address, .read, .write, .writedata, .byteenable,
  .readdata, .waitrequest, .timerOut, .timerOutEn);
